// *** logic/ddr3_cal_pkg.sv ***
/*
 * Shared constants, command encoding and latency helpers for the DDR3 read path
 * and calibration-pattern link. Assumes both ends are compiled against this package.
 */
package ddr3_cal_pkg;
	localparam int DQ_WIDTH   = 4;
	localparam int BEATS      = 8;
	localparam int CHOP_BEATS = 4;
	localparam int ADDR_W     = 14;
	localparam int BA_W       = 3;

	localparam logic [2:0] MR_ZERO  = 3'h0;
	localparam logic [2:0] MR_ONE   = 3'h1;
	localparam logic [2:0] MR_THREE = 3'h3;

	localparam logic [1:0] BL_FIXED8   = 2'h0;
	localparam logic [1:0] BL_OTF      = 2'h1;
	localparam logic [1:0] BL_FIXED4   = 2'h2;
	localparam logic [1:0] LOC_PATTERN = 2'h0;

	localparam int MR0_CL_LSB                = 4;
	localparam int MR1_AL_LSB                = 3;
	localparam int MR3_PATTERN_BIT           = 2;
	localparam int NIBBLE_SELECT_BIT         = 2;
	localparam int COLUMN_WORD_LSB           = 3;
	localparam int AUTO_PRECHARGE_SELECT_BIT = 10;
	localparam int BURST_CHOP_SELECT_BIT     = 12;

	localparam logic [4:0]  CL_BASE   = 5'h4;
	localparam logic [13:0] MR0_RESET = 14'h0010;

	// delays in command-clock cycles
	localparam int COLUMN_COMMAND_SPACING  = 4;
	localparam int PRECHARGE_WAIT_TIME     = 4;
	localparam int MODE_SET_COMMAND_DELAY  = 4;
	localparam int MODE_UPDATE_DELAY       = 12;
	localparam int PATTERN_RECOVERY_TIME   = 1;

	localparam int         REG_ADDR_W = 4;
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_MR0    = 4'h4;
	localparam logic [3:0] REG_MR1    = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int CTRL_GO        = 0;
	localparam int CTRL_CHOP_PIN  = 1;
	localparam int CTRL_NIBBLE    = 2;
	localparam int CTRL_COUNT_LSB = 8;

	// pins are {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] PINS_NOP       = 4'h7;
	localparam logic [3:0] PINS_MODE_SET  = 4'h0;
	localparam logic [3:0] PINS_PRECHARGE = 4'h2;
	localparam logic [3:0] PINS_ACTIVATE  = 4'h3;
	localparam logic [3:0] PINS_WRITE     = 4'h4;
	localparam logic [3:0] PINS_READ      = 4'h5;

	typedef enum logic [2:0] {
		CMD_NOP, CMD_MODE_SET, CMD_PRECHARGE, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_OTHER
	} cmd_t;

	function automatic cmd_t decode_cmd(input logic [3:0] pins);
		if (pins[3]) return CMD_NOP;
		else if (pins == PINS_NOP) return CMD_NOP;
		else if (pins == PINS_MODE_SET) return CMD_MODE_SET;
		else if (pins == PINS_PRECHARGE) return CMD_PRECHARGE;
		else if (pins == PINS_ACTIVATE) return CMD_ACTIVATE;
		else if (pins == PINS_READ) return CMD_READ;
		else if (pins == PINS_WRITE) return CMD_WRITE;
		else return CMD_OTHER;
	endfunction

	function automatic logic [3:0] cmd_pins(input cmd_t c);
		case (c)
			CMD_MODE_SET:  return PINS_MODE_SET;
			CMD_PRECHARGE: return PINS_PRECHARGE;
			CMD_ACTIVATE:  return PINS_ACTIVATE;
			CMD_READ:      return PINS_READ;
			CMD_WRITE:     return PINS_WRITE;
			default:       return PINS_NOP;
		endcase
	endfunction

	function automatic logic [4:0] read_latency(input logic [13:0] mr0, input logic [13:0] mr1);
		logic [4:0] cl;
		logic [4:0] al;
		cl = 5'(mr0[MR0_CL_LSB +: 3]) + CL_BASE;
		case (mr1[MR1_AL_LSB +: 2])
			2'h1:    al = cl - 5'h1;
			2'h2:    al = cl - 5'h2;
			default: al = 5'h0;
		endcase
		return al + cl;
	endfunction

	function automatic logic is_chop(input logic [1:0] bl, input logic a12);
		return (bl == BL_FIXED4) || (bl == BL_OTF && !a12);
	endfunction
endpackage

// *** logic/ddr3_link.sv ***
/*
 * Command and data link between the controller end and the memory end.
 * Assumes the bench instantiates it once and joins both ends to it.
 */
interface ddr3_link #(parameter int DQ_W = ddr3_cal_pkg::DQ_WIDTH) ();
	logic                                 ck;
	logic                                 cs_n;
	logic                                 ras_n;
	logic                                 cas_n;
	logic                                 we_n;
	logic [ddr3_cal_pkg::BA_W-1:0]        ba;
	logic [ddr3_cal_pkg::ADDR_W-1:0]      a;
	logic [DQ_W-1:0]                      dq_o;
	logic                                 dq_oe_n;
	logic                                 dqs_o;
	logic                                 dqs_oe_n;
	logic [DQ_W-1:0]                      dq;
	logic                                 dqs;

	// undriven wires read as low
	assign dq  = dq_oe_n ? '0 : dq_o;
	assign dqs = dqs_oe_n ? 1'b0 : dqs_o;

	modport memory (input ck, cs_n, ras_n, cas_n, we_n, ba, a, output dq_o, dq_oe_n, dqs_o, dqs_oe_n);
	modport controller (output ck, cs_n, ras_n, cas_n, we_n, ba, a, input dq, dqs);
endinterface

// *** logic/link_edge.sv ***
/*
 * Two-flop synchroniser with edge detection for a pin from another domain.
 * Assumes the pin toggles slower than a quarter of ref_clk.
 */
module link_edge (
	input  wire logic ref_clk, // local clock
	input  wire logic rst_n,   // synchronous reset, low active
	input  wire logic pin,     // asynchronous pin
	output logic      level,   // synchronised level
	output logic      rise,    // one-cycle rising pulse
	output logic      fall     // one-cycle falling pulse
);
	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise  = sync & ~prev;
	assign fall  = ~sync & prev;
endmodule

// *** logic/ddr3_mem_end.sv ***
/*
 * Memory end: decodes commands on command-clock rises, holds the mode registers,
 * and returns array or calibration-pattern bursts with strobe after read latency.
 * Assumes the controller keeps commands stable around each command-clock rise.
 */
module ddr3_mem_end #(
	parameter int DQ_W       = ddr3_cal_pkg::DQ_WIDTH, // data lines
	parameter int WORDS      = 16,                     // array depth in bursts
	parameter int PIPE_DEPTH = 32                      // longest read latency
) (
	input  wire logic                                     ref_clk,    // local clock
	input  wire logic                                     rst_n,      // synchronous reset
	ddr3_link.memory                                      link,       // link to controller
	input  wire logic                                     dll_locked, // loop locked
	input  wire logic                                     load_en,    // array load strobe
	input  wire logic [$clog2(WORDS)-1:0]                 load_addr,  // array load index
	input  wire logic [ddr3_cal_pkg::BEATS*DQ_W-1:0]      load_word,  // array load data
	output logic                                          pattern_mode // pattern readout on
);
	import ddr3_cal_pkg::*;

	localparam int WORD_W = BEATS * DQ_W;
	localparam int AW     = $clog2(WORDS);
	localparam int PW     = $clog2(PIPE_DEPTH);
	localparam int CMD_W  = 4 + BA_W + ADDR_W;

	typedef struct packed {
		logic              valid;
		logic              chop;
		logic [WORD_W-1:0] data;
	} slot_t;

	logic              ck_rise;
	logic              ck_fall;
	logic [CMD_W-1:0]  cmd_meta;
	logic [CMD_W-1:0]  cmd_s;
	logic [3:0]        pins;
	logic [BA_W-1:0]   ba;
	logic [ADDR_W-1:0] a;
	cmd_t              cmd;
	logic [13:0]       mr0;
	logic [13:0]       mr1;
	logic [13:0]       mr3;
	logic [4:0]        rl;
	logic [WORD_W-1:0] mem [WORDS];
	slot_t             pipe [PIPE_DEPTH];
	slot_t             new_slot;
	slot_t             start_slot;
	slot_t             pre_slot;
	logic [WORD_W-1:0] beats;
	logic [3:0]        left;
	logic [DQ_W-1:0]   dq_q;
	logic              dq_oe_q;
	logic              dqs_q;
	logic              dqs_oe_q;
	logic              dll_meta;
	logic              dll_s;

	function automatic logic [WORD_W-1:0] pattern_word();
		logic [WORD_W-1:0] w;
		w = '0;
		for (int i = 0; i < BEATS; i++) begin
			w[i*DQ_W +: DQ_W] = {DQ_W{i[0]}};
		end
		return w;
	endfunction

	link_edge ck_edge (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin     (link.ck),
		.level   (),
		.rise    (ck_rise),
		.fall    (ck_fall)
	);

	// command pins ride the same two-flop delay as the clock
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cmd_meta <= '0;
			cmd_s    <= '0;
		end else begin
			cmd_meta <= {link.cs_n, link.ras_n, link.cas_n, link.we_n, link.ba, link.a};
			cmd_s    <= cmd_meta;
		end
	end

	// loop lock arrives from outside this clock
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dll_meta <= 1'b0;
			dll_s    <= 1'b0;
		end else begin
			dll_meta <= dll_locked;
			dll_s    <= dll_meta;
		end
	end

	assign pins = cmd_s[CMD_W-1 -: 4];
	assign ba   = cmd_s[ADDR_W +: BA_W];
	assign a    = cmd_s[ADDR_W-1:0];
	assign cmd  = decode_cmd(pins);
	// latency from modes zero and one
	assign rl   = read_latency(mr0, mr1);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mr0 <= MR0_RESET;
			mr1 <= '0;
			mr3 <= '0;
		end else if (ck_rise && cmd == CMD_MODE_SET) begin
			if (ba == MR_ZERO) mr0 <= a;
			else if (ba == MR_ONE) mr1 <= a;
			else if (ba == MR_THREE) mr3 <= a;
		end
	end

	assign pattern_mode = mr3[MR3_PATTERN_BIT];

	always_ff @(posedge ref_clk) begin
		if (load_en) begin
			mem[load_addr] <= load_word;
		end
	end

	always_comb begin
		new_slot = '0;
		new_slot.valid = ck_rise && cmd == CMD_READ && dll_s;
		new_slot.chop = is_chop(mr0[1:0], a[BURST_CHOP_SELECT_BIT]);
		if (!mr3[MR3_PATTERN_BIT]) new_slot.data = mem[a[COLUMN_WORD_LSB +: AW]];
		else if (mr3[1:0] == LOC_PATTERN) new_slot.data = pattern_word();
		else new_slot.data = '0;
		if (new_slot.chop && a[NIBBLE_SELECT_BIT]) begin
			new_slot.data = {new_slot.data[WORD_W/2-1:0], new_slot.data[WORD_W-1:WORD_W/2]};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int k = 0; k < PIPE_DEPTH; k++) begin
				pipe[k] <= '0;
			end
		end else if (ck_rise) begin
			pipe[0] <= new_slot;
			for (int k = 1; k < PIPE_DEPTH; k++) begin
				pipe[k] <= pipe[k-1];
			end
		end
	end

	// burst at latency, preamble one earlier
	assign start_slot = pipe[PW'(rl) - PW'(1)];
	assign pre_slot   = pipe[PW'(rl) - PW'(2)];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			beats    <= '0;
			left     <= '0;
			dq_q     <= '0;
			dq_oe_q  <= 1'b1;
			dqs_q    <= 1'b0;
			dqs_oe_q <= 1'b1;
		end else if (ck_rise) begin
			// a new burst takes over the ending edge
			if (start_slot.valid) begin
				// first bit with first strobe rise
				dq_q     <= start_slot.data[DQ_W-1:0];
				beats    <= start_slot.data >> DQ_W;
				left     <= start_slot.chop ? 4'(CHOP_BEATS - 1) : 4'(BEATS - 1);
				dq_oe_q  <= 1'b0;
				dqs_q    <= 1'b1;
				dqs_oe_q <= 1'b0;
			end else if (left != 4'h0) begin
				dq_q  <= beats[DQ_W-1:0];
				beats <= beats >> DQ_W;
				left  <= left - 4'h1;
				dqs_q <= 1'b1;
			end else begin
				dq_oe_q  <= 1'b1;
				dqs_q    <= 1'b0;
				dqs_oe_q <= ~pre_slot.valid;
			end
		end else if (ck_fall && left != 4'h0) begin
			// later bits on following strobe edges
			dq_q  <= beats[DQ_W-1:0];
			beats <= beats >> DQ_W;
			left  <= left - 4'h1;
			dqs_q <= 1'b0;
		end
	end

	assign link.dq_o     = dq_q;
	assign link.dq_oe_n  = dq_oe_q;
	assign link.dqs_o    = dqs_q;
	assign link.dqs_oe_n = dqs_oe_q;
endmodule

// *** logic/ddr3_ctrl_end.sv ***
/*
 * Controller end: makes the command clock by division, runs the calibration
 * sequence on command, captures returned pattern beats and reports counts.
 * Assumes software reaches the registers over a one-cycle strobe port.
 */
module ddr3_ctrl_end #(
	parameter int DQ_W    = ddr3_cal_pkg::DQ_WIDTH, // data lines
	parameter int CK_HALF = 4                       // ref cycles per half command clock
) (
	input  wire logic                                ref_clk,   // local clock
	input  wire logic                                rst_n,     // synchronous reset
	ddr3_link.controller                             link,      // link to memory
	input  wire logic [ddr3_cal_pkg::REG_ADDR_W-1:0] reg_addr,  // register address
	input  wire logic [31:0]                         reg_wdata, // write data
	input  wire logic                                reg_wr,    // write strobe
	input  wire logic                                reg_rd,    // read strobe
	output logic [31:0]                              reg_rdata  // read data, next cycle
);
	import ddr3_cal_pkg::*;

	localparam int         DW        = $clog2(CK_HALF) + 1;
	localparam logic [7:0] W_SET     = 8'(MODE_SET_COMMAND_DELAY - 1);
	localparam logic [7:0] W_UPDATE  = 8'(MODE_UPDATE_DELAY - 1);
	localparam logic [7:0] W_BOTH    = (MODE_UPDATE_DELAY > MODE_SET_COMMAND_DELAY) ? W_UPDATE : W_SET;
	localparam logic [7:0] W_RP      = 8'(PRECHARGE_WAIT_TIME - 1);
	localparam logic [7:0] W_SPACING = 8'(COLUMN_COMMAND_SPACING - 1);
	localparam logic [7:0] W_TAIL    = 8'(BEATS / 2 + PATTERN_RECOVERY_TIME);

	typedef enum {
		S_IDLE, S_MR0, S_MR1, S_PRECHARGE, S_PATTERN_ON, S_READ, S_PATTERN_OFF, S_WAIT
	} state_t;

	state_t            state;
	state_t            after;
	logic [DW-1:0]     div;
	logic              ck_q;
	logic              ck_fall;
	logic [3:0]        pins_q;
	logic [BA_W-1:0]   ba_q;
	logic [ADDR_W-1:0] a_q;
	logic [15:0]       ctrl;
	logic [13:0]       mr0_cfg;
	logic [13:0]       mr1_cfg;
	logic              start_req;
	logic              take;
	logic              busy;
	logic              done;
	logic              pattern_on;
	logic [7:0]        wait_cnt;
	logic [7:0]        gap;
	logic [7:0]        reads_left;
	logic [4:0]        rl;
	logic              dqs_rise;
	logic              dqs_fall;
	logic [DQ_W-1:0]   dq_meta;
	logic [DQ_W-1:0]   dq_s;
	logic [7:0]        beat_cnt;
	logic [7:0]        err_cnt;
	logic              read_chop;

	assign rl      = read_latency(mr0_cfg, mr1_cfg);
	// full reads keep a12 high and a2 low
	assign read_chop = is_chop(mr0_cfg[1:0], ctrl[CTRL_CHOP_PIN]);
	assign ck_fall = ck_q && div == DW'(CK_HALF - 1);
	assign take    = ck_fall && state == S_IDLE && start_req;

	// command clock divider
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			div  <= '0;
			ck_q <= 1'b0;
		end else if (div == DW'(CK_HALF - 1)) begin
			div  <= '0;
			ck_q <= ~ck_q;
		end else begin
			div <= div + DW'(1);
		end
	end

	// register writes; a go while busy is ignored
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			ctrl    <= '0;
			mr0_cfg <= MR0_RESET;
			mr1_cfg <= '0;
		end else if (reg_wr) begin
			if (reg_addr == REG_CTRL) ctrl <= reg_wdata[15:0];
			else if (reg_addr == REG_MR0) mr0_cfg <= reg_wdata[13:0];
			else if (reg_addr == REG_MR1) mr1_cfg <= reg_wdata[13:0];
		end
	end

	// request flag: a new go wins over the take
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			start_req <= 1'b0;
		end else if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_GO] && !busy) begin
			start_req <= 1'b1;
		end else if (take) begin
			start_req <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (reg_addr == REG_CTRL) reg_rdata <= {16'h0000, ctrl};
			else if (reg_addr == REG_MR0) reg_rdata <= {18'h00000, mr0_cfg};
			else if (reg_addr == REG_MR1) reg_rdata <= {18'h00000, mr1_cfg};
			else if (reg_addr == REG_STATUS) reg_rdata <= {8'h00, err_cnt, beat_cnt, 5'h00, pattern_on, done, busy};
			else reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
		end
	end

	// sequencer; the pins change half a clock before the memory samples
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state      <= S_IDLE;
			after      <= S_IDLE;
			pins_q     <= PINS_NOP;
			ba_q       <= '0;
			a_q        <= '0;
			wait_cnt   <= '0;
			gap        <= '0;
			reads_left <= '0;
			busy       <= 1'b0;
			done       <= 1'b0;
			pattern_on <= 1'b0;
		end else if (ck_fall) begin
			pins_q <= PINS_NOP;
			case (state)
				S_IDLE: begin
					if (start_req) begin
						state <= S_MR0;
						busy  <= 1'b1;
						done  <= 1'b0;
					end
				end
				S_MR0: begin
					pins_q   <= cmd_pins(CMD_MODE_SET);
					ba_q     <= MR_ZERO;
					a_q      <= mr0_cfg;
					wait_cnt <= W_SET;
					after    <= S_MR1;
					state    <= S_WAIT;
				end
				S_MR1: begin
					pins_q   <= cmd_pins(CMD_MODE_SET);
					ba_q     <= MR_ONE;
					a_q      <= mr1_cfg;
					wait_cnt <= W_UPDATE;
					after    <= S_PRECHARGE;
					state    <= S_WAIT;
				end
				S_PRECHARGE: begin
					// precharge all, then row precharge wait
					pins_q   <= cmd_pins(CMD_PRECHARGE);
					a_q      <= '0;
					a_q[AUTO_PRECHARGE_SELECT_BIT] <= 1'b1;
					wait_cnt <= W_RP;
					after    <= S_PATTERN_ON;
					state    <= S_WAIT;
				end
				S_PATTERN_ON: begin
					pins_q     <= cmd_pins(CMD_MODE_SET);
					ba_q       <= MR_THREE;
					a_q        <= '0;
					a_q[MR3_PATTERN_BIT] <= 1'b1;
					pattern_on <= 1'b1;
					wait_cnt   <= W_BOTH;
					after      <= S_READ;
					state      <= S_WAIT;
					gap        <= '0;
					reads_left <= ctrl[CTRL_COUNT_LSB +: 8];
				end
				S_READ: begin
					if (gap != 8'h00) begin
						gap <= gap - 8'h01;
					end else begin
						pins_q <= cmd_pins(CMD_READ);
						ba_q   <= '0;
						a_q    <= '0;
						a_q[BURST_CHOP_SELECT_BIT] <= ~read_chop;
						a_q[NIBBLE_SELECT_BIT]     <= ctrl[CTRL_NIBBLE] & read_chop;
						gap    <= W_SPACING;
						if (reads_left <= 8'h01) begin
							wait_cnt <= 8'(rl) + W_TAIL;
							after    <= S_PATTERN_OFF;
							state    <= S_WAIT;
						end else begin
							reads_left <= reads_left - 8'h01;
						end
					end
				end
				S_PATTERN_OFF: begin
					pins_q     <= cmd_pins(CMD_MODE_SET);
					ba_q       <= MR_THREE;
					a_q        <= '0;
					pattern_on <= 1'b0;
					wait_cnt   <= W_BOTH;
					after      <= S_IDLE;
					state      <= S_WAIT;
				end
				S_WAIT: begin
					if (wait_cnt != 8'h00) begin
						wait_cnt <= wait_cnt - 8'h01;
					end else begin
						state <= after;
						if (after == S_IDLE) begin
							busy <= 1'b0;
							done <= 1'b1;
						end
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	link_edge dqs_edge (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin     (link.dqs),
		.level   (),
		.rise    (dqs_rise),
		.fall    (dqs_fall)
	);

	// beat capture and pattern check on each strobe edge
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dq_meta  <= '0;
			dq_s     <= '0;
			beat_cnt <= '0;
			err_cnt  <= '0;
		end else begin
			dq_meta <= link.dq;
			dq_s    <= dq_meta;
			if (take) begin
				beat_cnt <= '0;
				err_cnt  <= '0;
			end else if (dqs_rise || dqs_fall) begin
				beat_cnt <= beat_cnt + 8'h01;
				if (dq_s != {DQ_W{beat_cnt[0]}}) err_cnt <= err_cnt + 8'h01;
			end
		end
	end

	assign link.ck    = ck_q;
	assign link.cs_n  = pins_q[3];
	assign link.ras_n = pins_q[2];
	assign link.cas_n = pins_q[1];
	assign link.we_n  = pins_q[0];
	assign link.ba    = ba_q;
	assign link.a     = a_q;
endmodule

// *** tb/ddr3_cal_assertions.sv ***
/*
 * Checker for the command and data link between the two ends.
 * Assumes the bench hands it the link signals and the local clock and reset.
 */
module ddr3_cal_assertions #(
	parameter int DQ_W = 4 // data lines
) (
	input wire logic                               ref_clk,  // local clock
	input wire logic                               rst_n,    // synchronous reset
	input wire logic                               ck,       // command clock
	input wire logic                               cs_n,     // select
	input wire logic                               ras_n,    // row strobe
	input wire logic                               cas_n,    // column strobe
	input wire logic                               we_n,     // write enable
	input wire logic [ddr3_cal_pkg::ADDR_W-1:0]    a,        // address
	input wire logic [DQ_W-1:0]                    dq_o,     // data out
	input wire logic                               dq_oe_n,  // data drive
	input wire logic                               dqs_o,    // strobe out
	input wire logic                               dqs_oe_n  // strobe drive
);
	timeunit 1ns;
	timeprecision 1ps;
	import ddr3_cal_pkg::*;
	logic [7:0] run;
	logic [3:0] pins;
	assign pins = {cs_n, ras_n, cas_n, we_n};
	// length of the current data drive window
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			run <= 8'h0;
		else if (!dq_oe_n)
			run <= run + 8'h1;
		else
			run <= 8'h0;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_pre; $fell(dqs_oe_n) |-> (dq_oe_n && !dqs_o)[*8] ##1 !dq_oe_n; endproperty
	property p_first; $fell(dq_oe_n) |-> dqs_o && !dqs_oe_n; endproperty
	property p_cover; !dq_oe_n |-> !dqs_oe_n; endproperty
	property p_pat; !dq_oe_n |-> dq_o == {DQ_W{~dqs_o}}; endproperty
	property p_beat; !dqs_oe_n && $changed(dqs_o) |=> $stable(dqs_o)[*3]; endproperty
	property p_len; $rose(dq_oe_n) |-> run[3:0] == 4'h0 && run != 8'h0; endproperty
	property p_cmd; $changed(pins) |-> !ck; endproperty
	property p_nowr; pins != PINS_WRITE; endproperty
	property p_rdaddr; pins == PINS_READ |-> a[1:0] == 2'h0; endproperty
	property p_full; pins == PINS_READ && a[BURST_CHOP_SELECT_BIT] |-> !a[NIBBLE_SELECT_BIT]; endproperty
	a_pre: assert property (p_pre) else $error("strobe preamble not one command clock");
	a_first: assert property (p_first) else $error("first beat not on strobe rise");
	a_cover: assert property (p_cover) else $error("data driven without strobe");
	a_pat: assert property (p_pat) else $error("beat not alternating on all lines");
	a_beat: assert property (p_beat) else $error("strobe half period wrong");
	a_len: assert property (p_len) else $error("burst drive length wrong");
	a_cmd: assert property (p_cmd) else $error("command changed while clock high");
	a_nowr: assert property (p_nowr) else $error("write command issued");
	a_rdaddr: assert property (p_rdaddr) else $error("read low address not zero");
	a_full: assert property (p_full) else $error("full read with nibble bit set");
	c_pre: cover property ($fell(dqs_oe_n));
	c_b2b: cover property (run == 8'h40);
	c_rd: cover property (pins == PINS_READ);
endmodule

// *** tb/ddr3_read_path_calibration_bench.sv ***
/*
 * Bench joining controller end and memory end over the link.
 * Assumes the array preload port is unused: only pattern reads are made.
 */
module ddr3_read_path_calibration_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ddr3_cal_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        dll_locked = 1'b1;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        pattern_mode;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] st;
	int          n_fail = 0;
	int          n_checks = 0;
	int          nck = 0;
	int          t_rd = -1;
	int          t_dq = -1;
	bit          pm_seen = 1'b0;
	ddr3_link link ();
	ddr3_mem_end i_ddr3_mem_end (.ref_clk, .rst_n, .link, .dll_locked, .load_en(1'b0), .load_addr(4'h0),
		.load_word(32'h0), .pattern_mode);
	ddr3_ctrl_end i_ddr3_ctrl_end (.ref_clk, .rst_n, .link, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	ddr3_cal_assertions #(.DQ_W(DQ_WIDTH)) i_ddr3_cal_assertions (.ref_clk, .rst_n, .ck(link.ck),
		.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .a(link.a),
		.dq_o(link.dq_o), .dq_oe_n(link.dq_oe_n), .dqs_o(link.dqs_o), .dqs_oe_n(link.dqs_oe_n));
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	// command clock rises counted from the first read to the first data
	always @(posedge link.ck) begin
		if ({link.cs_n, link.ras_n, link.cas_n, link.we_n} === PINS_READ && t_rd < 0)
			t_rd = nck;
		nck = nck + 1;
	end
	always @(negedge link.dq_oe_n) if (t_dq < 0) t_dq = nck;
	always @(posedge ref_clk) if (pattern_mode === 1'b1) pm_seen = 1'b1;
	task summarize;
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] ad, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
	// program modes, run the sequence, judge status, latency and mode flag
	task cal(input logic [13:0] m0, input logic [13:0] m1, input logic [7:0] ctl, input int edges, input int rl);
		int i;
		wr(REG_MR0, 32'(m0));
		wr(REG_MR1, 32'(m1));
		t_rd = -1;
		t_dq = -1;
		pm_seen = 1'b0;
		// ctl holds the read count in [7:3] and the low control bits in [2:0]
		wr(REG_CTRL, {16'h0, 3'h0, ctl[7:3], 5'h0, ctl[2:0]});
		repeat (20) @(posedge ref_clk);
		for (i = 0; i < 2000; i++) begin
			rd(REG_STATUS, st);
			if (st[0] === 1'b0) break;
		end
		chk(st & 32'h00FF_FF07, {16'h0, 8'(edges), 8'h02});
		chk(32'(pm_seen), 32'h1);
		chk(32'(pattern_mode), 32'h0);
		if (edges > 0) chk(32'(t_dq - t_rd - 1), 32'(rl));
	endtask
	task t_reset_regs;
		logic [31:0] d;
		rd(REG_MR0, d);
		chk(d, 32'h0000_0010);
		rd(4'h2, d);
		chk(d, 32'h0);
		rd(REG_STATUS, d);
		chk(d, 32'h0);
	endtask
	task t_bl8_single; cal(14'h0010, 14'h0000, 8'h09, 8, 5); endtask
	task t_bl8_b2b_al; cal(14'h0010, 14'h0008, 8'h11, 16, 9); endtask
	task t_chop_fixed; cal(14'h0022, 14'h0010, 8'h11, 8, 10); endtask
	task t_otf_chop_hi; cal(14'h0011, 14'h0000, 8'h0D, 4, 5); endtask
	task t_otf_full_zero; cal(14'h0011, 14'h0000, 8'h03, 8, 5); endtask
	task t_dll_off;
		dll_locked <= 1'b0;
		cal(14'h0010, 14'h0000, 8'h09, 0, 5);
		dll_locked <= 1'b1;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset_regs();
		t_bl8_single();
		t_bl8_b2b_al();
		t_chop_fixed();
		t_otf_chop_hi();
		t_otf_full_zero();
		t_dll_off();
		summarize();
	end
	initial begin
		#2000000;
		n_fail++;
		summarize();
	end
endmodule
